/* File: pkg/ncp_regs.vh */
/*
  constants for the host-side nand pointer and bad-block controller:
  command codes, column layout, marker column and timing counts.
  assumes a 40 MHz clock and an x8 part with a 528-byte page.
*/
`ifndef NCP_REGS_VH
`define NCP_REGS_VH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define NCP_CMD_FIRST_HALF  8'h00
`define NCP_CMD_SECOND_HALF 8'h01
`define NCP_CMD_SPARE       8'h50
`define NCP_CMD_PROG_SETUP  8'h80
`define NCP_CMD_PROG_CONF   8'h10
`define NCP_CMD_ERASE_SETUP 8'h60
`define NCP_CMD_ERASE_CONF  8'hD0
`define NCP_CMD_STATUS      8'h70
`define NCP_CMD_RESET       8'hFF

// ---------------------------------------------------------------
// pointer areas and page layout
// ---------------------------------------------------------------
`define NCP_AREA_FIRST      2'h0
`define NCP_AREA_SECOND     2'h1
`define NCP_AREA_SPARE      2'h2
`define NCP_MARK_COL        10'h205
`define NCP_ERASED_BYTE     8'hFF
`define NCP_STATUS_FAIL_BIT 0

// ---------------------------------------------------------------
// timing, nanoseconds or microseconds and derived cycle counts at 40 MHz
// ---------------------------------------------------------------
`define NCP_CLK_NS          25
`define NCP_SEL_HIGH_NS     100
`define NCP_SEL_HIGH_CYC    ((`NCP_SEL_HIGH_NS + `NCP_CLK_NS) / `NCP_CLK_NS)
`define NCP_STROBE_NS       50
`define NCP_STROBE_CYC      ((`NCP_STROBE_NS + `NCP_CLK_NS - 1) / `NCP_CLK_NS)
`define NCP_XFER_US         10
`define NCP_XFER_CYC        ((`NCP_XFER_US * 1000) / `NCP_CLK_NS)
`define NCP_RESET_US        5
`define NCP_RESET_CYC       ((`NCP_RESET_US * 1000) / `NCP_CLK_NS)

`endif

/* File: core/ncp_strobe.v */
/*
  one bus cycle on the flash pins: command, address or data write,
  or one data read. assumes the caller holds kind and data stable
  while busy is high.
*/
`include "ncp_regs.vh"

module ncp_strobe
(
  clock,
  rstn,
  go,
  kind,
  wrData,
  ioIn,
  busy,
  cmdLatch,
  addrLatch,
  writeStrobeN,
  readStrobeN,
  ioOut,
  ioOe,
  rdData
);
  input  wire       clock;
  input  wire       rstn;
  input  wire       go;
  input  wire [1:0] kind;    // 0 cmd, 1 addr, 2 data write, 3 data read
  input  wire [7:0] wrData;
  input  wire [7:0] ioIn;
  output reg        busy;
  output reg        cmdLatch;
  output reg        addrLatch;
  output reg        writeStrobeN;
  output reg        readStrobeN;
  output reg  [7:0] ioOut;
  output reg        ioOe;
  output reg  [7:0] rdData;

  reg [1:0] phase_q;

  // ---------------------------------------------------------------
  // low phase then high phase, two cycles each (50 ns)
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      busy         <= 1'b0;
      cmdLatch     <= 1'b0;
      addrLatch    <= 1'b0;
      writeStrobeN <= 1'b1;
      readStrobeN  <= 1'b1;
      ioOut        <= 8'h00;
      ioOe         <= 1'b0;
      rdData       <= 8'h00;
      phase_q      <= 2'h0;
    end
    else if (!busy)
    begin
      if (go)
      begin
        busy         <= 1'b1;
        phase_q      <= 2'h0;
        cmdLatch     <= (kind == 2'h0);
        addrLatch    <= (kind == 2'h1);
        ioOut        <= wrData;
        ioOe         <= (kind != 2'h3);
        writeStrobeN <= (kind == 2'h3);
        readStrobeN  <= (kind != 2'h3);
      end
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h1)
      begin
        if (!readStrobeN)
          rdData <= ioIn; // sample just before the rising read edge
        writeStrobeN <= 1'b1;
        readStrobeN  <= 1'b1;
      end
      if (phase_q == 2'h3)
      begin
        busy      <= 1'b0;
        cmdLatch  <= 1'b0;
        addrLatch <= 1'b0;
        ioOe      <= 1'b0;
      end
    end
  end

endmodule // ncp_strobe

/* File: core/ncp_host.v */
/*
  host controller for a byte-wide nand flash: pointer commands, page
  read, program and erase with status check, reset, bad-block scan and
  refusal of marked blocks other than block zero. assumes synchronous pin inputs and an external page
  buffer reached through the user byte ports.
*/
// Function
// - host sends 00h or 50h before 80h for first-half or spare programs
// - host sends 01h directly before 80h for second-half programs
// - host ends sequential read holding select high over 100 ns
// - host scans markers, builds invalid table, maps bad blocks out
// - host never erases factory invalid-block markers, except block zero's: the scan never marks it and it is never refused
// - host reads status after program or erase, retires failed blocks; a failed block zero is marked but never refused
// - host leaves single-bit read errors to the user's code, not replacement
`include "ncp_regs.vh"

module ncp_host
#(
  parameter BLOCKS     = 2048,
  parameter BLK_BITS   = 11,
  parameter XFER_CYC   = `NCP_XFER_CYC,
  parameter RESET_CYC  = `NCP_RESET_CYC
)
(
  clock,
  rstn,
  opStart,
  opCode,
  opBlock,
  opPage,
  opColumn,
  opLength,
  wrByte,
  wrByteReq,
  rdByte,
  rdByteValid,
  opDone,
  opFail,
  blockBad,
  flashBusyN,
  ioIn,
  selectN,
  cmdLatch,
  addrLatch,
  writeStrobeN,
  readStrobeN,
  ioOut,
  ioOe,
  hostBusy
);
  input  wire                clock;
  input  wire                rstn;
  input  wire                opStart;
  input  wire [2:0]          opCode;   // 0 read, 1 program, 2 erase, 3 reset, 4 scan
  input  wire [BLK_BITS-1:0] opBlock;
  input  wire [4:0]          opPage;
  input  wire [9:0]          opColumn;
  input  wire [9:0]          opLength;
  input  wire [7:0]          wrByte;
  output reg                 wrByteReq;
  output reg  [7:0]          rdByte;
  output reg                 rdByteValid;
  output reg                 opDone;
  output reg                 opFail;
  output reg                 blockBad;
  input  wire                flashBusyN;
  input  wire [7:0]          ioIn;
  output reg                 selectN;
  output wire                cmdLatch;
  output wire                addrLatch;
  output wire                writeStrobeN;
  output wire                readStrobeN;
  output wire [7:0]          ioOut;
  output wire                ioOe;
  output reg                 hostBusy;

  localparam S_IDLE = 4'h0, S_CMD = 4'h1, S_ADDR = 4'h2, S_WDATA = 4'h3;
  localparam S_CONF = 4'h4, S_WAIT = 4'h5, S_RDATA = 4'h6, S_STAT = 4'h7;
  localparam S_STRD = 4'h8, S_DESEL = 4'h9, S_SCAN = 4'hA, S_PTR = 4'hB;

  reg [3:0]          state_q;
  reg [2:0]          op_q;
  reg [BLK_BITS-1:0] blk_q;
  reg [4:0]          page_q;
  reg [9:0]          col_q;
  reg [9:0]          left_q;
  reg [1:0]          addrCnt_q;
  reg [1:0]          area_q;
  reg [13:0]         waitCnt_q;
  reg [2:0]          holdCnt_q;
  reg                badTable_q [0:BLOCKS-1];
  reg                go_q;
  reg [1:0]          kind_q;
  reg [7:0]          data_q;
  reg                sawBusy_q;
  integer            i;

  wire       strBusy;
  wire [7:0] strData;

  // ---------------------------------------------------------------
  // single bus-cycle engine
  // ---------------------------------------------------------------
  ncp_strobe u_strobe
  (
    .clock        (clock),
    .rstn         (rstn),
    .go           (go_q),
    .kind         (kind_q),
    .wrData       (data_q),
    .ioIn         (ioIn),
    .busy         (strBusy),
    .cmdLatch     (cmdLatch),
    .addrLatch    (addrLatch),
    .writeStrobeN (writeStrobeN),
    .readStrobeN  (readStrobeN),
    .ioOut        (ioOut),
    .ioOe         (ioOe),
    .rdData       (strData)
  );

  // pointer command for the start column's area
  wire [7:0] ptrCmd = (col_q[9]) ? `NCP_CMD_SPARE :
                      (col_q[8]) ? `NCP_CMD_SECOND_HALF : `NCP_CMD_FIRST_HALF;
  wire       idleStr = !strBusy && !go_q;

  // row address bytes: column low, then page/block; block bits fill the top byte
  wire [BLK_BITS+12:0] rowAddr = {blk_q, page_q, col_q[7:0]};

  // ---------------------------------------------------------------
  // main sequencer
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q     <= S_IDLE;
      op_q        <= 3'h0;
      blk_q       <= {BLK_BITS{1'b0}};
      page_q      <= 5'h00;
      col_q       <= 10'h000;
      left_q      <= 10'h000;
      addrCnt_q   <= 2'h0;
      area_q      <= `NCP_AREA_FIRST;
      waitCnt_q   <= 14'h0000;
      holdCnt_q   <= 3'h0;
      go_q        <= 1'b0;
      kind_q      <= 2'h0;
      data_q      <= 8'h00;
      sawBusy_q   <= 1'b0;
      wrByteReq   <= 1'b0;
      rdByte      <= 8'h00;
      rdByteValid <= 1'b0;
      opDone      <= 1'b0;
      opFail      <= 1'b0;
      blockBad    <= 1'b0;
      selectN     <= 1'b1;
      hostBusy    <= 1'b0;
      for (i = 0; i < BLOCKS; i = i + 1)
        badTable_q[i] <= 1'b0;
    end
    else
    begin
      go_q        <= 1'b0;
      wrByteReq   <= 1'b0;
      rdByteValid <= 1'b0;
      opDone      <= 1'b0;
      blockBad    <= badTable_q[opBlock]; // table lookup for address mapping
      case (state_q)
        S_IDLE:
        begin
          if (opStart)
          begin
            op_q      <= opCode;
            blk_q     <= opBlock;
            page_q    <= (opCode == 3'h4) ? 5'h00 : opPage;
            col_q     <= (opCode == 3'h4) ? `NCP_MARK_COL : opColumn;
            left_q    <= opLength;
            opFail    <= 1'b0;
            hostBusy  <= 1'b1;
            selectN   <= 1'b0;
            // skip mapped-out blocks; block zero is never skipped
            if (badTable_q[opBlock] && opCode != 3'h4 && opBlock != 0)
            begin
              opFail   <= 1'b1;
              opDone   <= 1'b1;
              hostBusy <= 1'b0;
              selectN  <= 1'b1;
            end
            else
              state_q <= S_PTR;
          end
        end
        S_PTR:
        begin
          if (idleStr)
          begin
            go_q   <= 1'b1;
            kind_q <= 2'h0;
            // pointer goes out right before 80h / read address
            if (opCode_isReset(op_q))
              data_q <= `NCP_CMD_RESET;
            else if (op_q == 3'h2)
              data_q <= `NCP_CMD_ERASE_SETUP;
            else
            begin
              data_q <= ptrCmd;
              area_q <= col_q[9] ? `NCP_AREA_SPARE :
                        col_q[8] ? `NCP_AREA_SECOND : `NCP_AREA_FIRST;
            end
            addrCnt_q <= (op_q == 3'h2) ? 2'h1 : 2'h0;
            state_q   <= opCode_isReset(op_q) ? S_WAIT : (op_q == 3'h1) ? S_CMD : S_ADDR;
            waitCnt_q <= 14'h0000;
            sawBusy_q <= 1'b0;
          end
        end
        S_CMD:
        begin
          if (idleStr)
          begin
            go_q    <= 1'b1;
            kind_q  <= 2'h0;
            data_q  <= `NCP_CMD_PROG_SETUP;
            state_q <= S_ADDR;
          end
        end
        S_ADDR:
        begin
          if (idleStr)
          begin
            go_q      <= 1'b1;
            kind_q    <= 2'h1;
            data_q    <= rowAddr[8*addrCnt_q +: 8];
            addrCnt_q <= addrCnt_q + 2'h1;
            if (addrCnt_q == 2'h2)
              state_q <= (op_q == 3'h1) ? S_WDATA : (op_q == 3'h2) ? S_CONF : S_WAIT;
            if (addrCnt_q == 2'h2 && op_q == 3'h1)
              wrByteReq <= 1'b1;
          end
        end
        S_WDATA:
        begin
          if (idleStr && !wrByteReq)
          begin
            go_q   <= 1'b1;
            kind_q <= 2'h2;
            data_q <= wrByte;
            left_q <= left_q - 10'h001;
            if (left_q == 10'h001)
              state_q <= S_CONF;
            else
              wrByteReq <= 1'b1;
          end
        end
        S_CONF:
        begin
          if (idleStr)
          begin
            go_q      <= 1'b1;
            kind_q    <= 2'h0;
            data_q    <= (op_q == 3'h1) ? `NCP_CMD_PROG_CONF : `NCP_CMD_ERASE_CONF;
            waitCnt_q <= 14'h0000;
            sawBusy_q <= 1'b0;
            state_q   <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          // wait for ready after a busy period, bounded by the limit
          if (idleStr)
          begin
            waitCnt_q <= waitCnt_q + 14'h0001;
            if (!flashBusyN)
              sawBusy_q <= 1'b1;
            if ((sawBusy_q && flashBusyN) || waitCnt_q == 14'h3FFF)
            begin
              if (op_q == 3'h1 || op_q == 3'h2)
                state_q <= S_STAT;
              else if (opCode_isReset(op_q))
              begin
                opFail  <= (waitCnt_q > RESET_CYC[13:0]);
                state_q <= S_DESEL;
              end
              else
              begin
                opFail  <= (waitCnt_q > XFER_CYC[13:0]);
                state_q <= S_RDATA;
              end
            end
          end
        end
        S_RDATA, S_SCAN:
        begin
          if (idleStr)
          begin
            go_q   <= 1'b1;
            kind_q <= 2'h3;
            state_q <= S_STRD;
          end
        end
        S_STRD:
        begin
          if (idleStr)
          begin
            if (op_q == 3'h4)
            begin
              // marker check on page 0 then page 1
              if (strData != `NCP_ERASED_BYTE && blk_q != 0)
              begin
                badTable_q[blk_q] <= 1'b1;
                state_q <= S_DESEL;
              end
              else if (page_q == 5'h00)
              begin
                page_q  <= 5'h01;
                state_q <= S_DESEL;
                left_q  <= 10'h3FF; // flag: re-run on page 1
              end
              else
                state_q <= S_DESEL;
            end
            else if (op_q == 3'h1 || op_q == 3'h2)
            begin
              if (strData[`NCP_STATUS_FAIL_BIT])
              begin
                badTable_q[blk_q] <= 1'b1;
                opFail <= 1'b1;
              end
              state_q <= S_DESEL;
            end
            else
            begin
              // read bytes pass through untouched: correction is left to the
              // user's code, a read never retires a block
              rdByte      <= strData;
              rdByteValid <= 1'b1;
              left_q      <= left_q - 10'h001;
              state_q     <= (left_q == 10'h001) ? S_DESEL : S_RDATA;
            end
          end
        end
        S_STAT:
        begin
          if (idleStr)
          begin
            go_q    <= 1'b1;
            kind_q  <= 2'h0;
            data_q  <= `NCP_CMD_STATUS;
            state_q <= S_SCAN;
          end
        end
        S_DESEL:
        begin
          // select held high long enough to end any sequential read
          if (idleStr)
          begin
            selectN   <= 1'b1;
            holdCnt_q <= holdCnt_q + 3'h1;
            if (holdCnt_q == `NCP_SEL_HIGH_CYC)
            begin
              holdCnt_q <= 3'h0;
              // one-shot second half falls back to the first half
              if (area_q == `NCP_AREA_SECOND)
                area_q <= `NCP_AREA_FIRST;
              if (op_q == 3'h4 && left_q == 10'h3FF)
              begin
                left_q  <= 10'h000;
                selectN <= 1'b0;
                state_q <= S_PTR;
              end
              else
              begin
                opDone   <= 1'b1;
                hostBusy <= 1'b0;
                state_q  <= S_IDLE;
              end
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  function opCode_isReset;
    input [2:0] op;
    begin
      opCode_isReset = (op == 3'h3);
    end
  endfunction

endmodule // ncp_host

/* File: sim/ncp_host_asserts.sv */
/*
  pin-level checks of the nand host controller ncp_host.
  assumes the bind at the foot reaches every ncp_host instance.
*/
module ncp_host_asserts
(
  input logic       clock,
  input logic       rstn,
  input logic       opStart,
  input logic       hostBusy,
  input logic       opDone,
  input logic       blockBad,
  input logic       selectN,
  input logic       cmdLatch,
  input logic       writeStrobeN,
  input logic       readStrobeN,
  input logic [7:0] ioOut,
  input logic       ioOe,
  input logic       flashBusyN
);
  logic       weHigh_q;
  logic [7:0] curCmd_q;
  wire        cmdFall = cmdLatch && !writeStrobeN && weHigh_q;
  // remembers the last command put on the pins
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      weHigh_q <= 1'b1;
      curCmd_q <= 8'hFF;
    end
    else
    begin
      weHigh_q <= writeStrobeN;
      if (cmdFall)
        curCmd_q <= ioOut;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_sel_hold;
    $rose(selectN) |-> selectN [*5];
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select high too short");
  property p_ptr_prog;
    cmdFall && ioOut == 8'h80 |-> curCmd_q inside {8'h00, 8'h01, 8'h50};
  endproperty
  a_ptr_prog: assert property (p_ptr_prog) else $error("no pointer before 80h");
  property p_status;
    cmdFall && (curCmd_q == 8'h10 || curCmd_q == 8'hD0) |-> ioOut == 8'h70;
  endproperty
  a_status: assert property (p_status) else $error("no status after confirm");
  property p_no_erase_bad;
    hostBusy && blockBad |-> !(cmdFall && ioOut == 8'hD0);
  endproperty
  a_no_erase_bad: assert property (p_no_erase_bad) else $error("bad block erased");
  property p_done_idle;
    opDone |-> selectN && !ioOe && readStrobeN;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("pins busy at done");
  property p_done_pulse;
    opDone |=> !opDone;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
  property p_start;
    opStart && !hostBusy |=> hostBusy || opDone;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_we_width;
    $fell(writeStrobeN) |=> !writeStrobeN ##1 writeStrobeN ##1 writeStrobeN;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
  property p_rd_ready;
    $fell(readStrobeN) |-> flashBusyN;
  endproperty
  a_rd_ready: assert property (p_rd_ready) else $error("read while flash busy");
endmodule // ncp_host_asserts

bind ncp_host ncp_host_asserts chk
(
  .clock(clock), .rstn(rstn), .opStart(opStart), .hostBusy(hostBusy), .opDone(opDone),
  .blockBad(blockBad), .selectN(selectN), .cmdLatch(cmdLatch),
  .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN), .ioOut(ioOut), .ioOe(ioOe),
  .flashBusyN(flashBusyN)
);

/* File: sim/ncp_flash_model.sv */
/*
  behavioural byte-wide nand flash at its pins: pointer, busy times,
  status and the factory invalid-block marker of one block.
  assumes the host holds pins steady around its strobe edges.
*/
module ncp_flash_model
#(
  parameter int XFER_NS  = 1000,
  parameter int RESET_NS = 500
)
(
  input  wire         selectN,
  input  wire         cmdLatch,
  input  wire         addrLatch,
  input  wire         writeStrobeN,
  input  wire         readStrobeN,
  input  wire  [7:0]  ioOut,
  input  wire  [10:0] badBlk,
  input  wire         slow,
  input  wire         failProg,
  output logic        flashBusyN,
  output logic [7:0]  ioIn,
  output logic [1:0]  area,
  output logic [9:0]  startCol
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  cmd;
  logic [7:0]  adr [0:2];
  logic [9:0]  col;
  logic [15:0] row;
  int          nAdr;
  // busy low for a prompt or slow interval, second half then expires
  task automatic goBusy(input int ns);
    flashBusyN = 1'b0;
    #(slow ? ns * 8 : ns);
    flashBusyN = 1'b1;
    if (area == 2'h1)
      area = 2'h0;
  endtask
  // power-up state
  initial
  begin
    flashBusyN = 1'b1;
    ioIn = 8'h00;
    area = 2'h0;
    startCol = 10'h000;
    cmd = 8'hFF;
    nAdr = 0;
  end
  // commands and addresses latch on the rising write strobe
  always @(posedge writeStrobeN)
  begin
    if (!selectN && cmdLatch)
    begin
      cmd = ioOut;
      nAdr = (ioOut == 8'h60) ? 1 : 0;
      case (ioOut)
        8'h00: area = 2'h0;
        8'h01: area = 2'h1;
        8'h50: area = 2'h2;
        8'h10, 8'hD0: goBusy(XFER_NS);
        8'hFF: goBusy(RESET_NS);
        default: ;
      endcase
    end
    else if (!selectN && addrLatch && nAdr < 3)
    begin
      adr[nAdr] = ioOut;
      nAdr++;
      col = (area == 2'h2) ? {6'h20, adr[0][3:0]} : {area, adr[0]};
      if (nAdr == 3 && cmd != 8'h60)
        startCol = col;
      if (nAdr == 3 && cmd != 8'h80 && cmd != 8'h60)
        goBusy(XFER_NS);
    end
  end
  // read data or status on the falling read strobe
  always @(negedge readStrobeN)
  begin
    row = {adr[2], adr[1]};
    if (cmd == 8'h70)
      ioIn = {7'h00, failProg};
    else if (row[15:5] == badBlk && row[4:0] == 5'h01 && col == 10'h205)
      ioIn = 8'h00;
    else
      ioIn = 8'hFF;
    col = col + 10'h001;
  end
  // the bus no longer holds the byte once the hold time is over
  always @(posedge readStrobeN)
    #15 ioIn = ~ioIn;
endmodule // ncp_flash_model

/* File: sim/tb_nand_column_pointer_and_bad_block.sv */
/*
  self-checking bench: ncp_host driving the behavioural flash model.
  assumes the checker binds itself from its own file.
*/
module tb_nand_column_pointer_and_bad_block;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, rstn, opStart, slow, failProg;
  logic [2:0]  opCode;
  logic [10:0] opBlock;
  logic [4:0]  opPage;
  logic [9:0]  opColumn, opLength;
  logic [7:0]  wrByte, lastRd;
  wire         wrByteReq, rdByteValid, opDone, opFail, blockBad, hostBusy;
  wire         flashBusyN, selectN, cmdLatch, addrLatch, writeStrobeN, readStrobeN, ioOe;
  wire  [7:0]  rdByte, ioIn, ioOut;
  wire  [1:0]  area;
  wire  [9:0]  startCol;
  int          mismatches, samplesChecked, nRd, nWr;
  ncp_host uut
  (
    .clock(clock), .rstn(rstn), .opStart(opStart), .opCode(opCode), .opBlock(opBlock),
    .opPage(opPage), .opColumn(opColumn), .opLength(opLength), .wrByte(wrByte),
    .wrByteReq(wrByteReq), .rdByte(rdByte), .rdByteValid(rdByteValid), .opDone(opDone),
    .opFail(opFail), .blockBad(blockBad), .flashBusyN(flashBusyN), .ioIn(ioIn),
    .selectN(selectN), .cmdLatch(cmdLatch), .addrLatch(addrLatch), .ioOe(ioOe),
    .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN), .ioOut(ioOut),
    .hostBusy(hostBusy)
  );
  ncp_flash_model flash
  (
    .selectN(selectN), .cmdLatch(cmdLatch), .addrLatch(addrLatch), .ioOut(ioOut),
    .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN), .badBlk(11'h007),
    .slow(slow), .failProg(failProg), .flashBusyN(flashBusyN), .ioIn(ioIn),
    .area(area), .startCol(startCol)
  );
  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic checkVec(input string name, input logic [9:0] expV, input logic [9:0] gotV);
    samplesChecked++;
    if (gotV !== expV)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, expV, gotV);
    end
  endtask
  task automatic checkBit(input string name, input logic expV, input logic gotV);
    checkVec(name, {9'h000, expV}, {9'h000, gotV});
  endtask
  // one operation, counting bytes until done under a bound
  task automatic runOp(input logic [2:0] code, input logic [10:0] blk, input logic [4:0] page,
                       input logic [9:0] col, input logic [9:0] len);
    int n;
    nRd = 0;
    nWr = 0;
    @(posedge clock);
    opStart <= 1'b1;
    opCode <= code;
    opBlock <= blk;
    opPage <= page;
    opColumn <= col;
    opLength <= len;
    for (n = 0; n < 20000; n++)
    begin
      @(posedge clock);
      opStart <= 1'b0;
      wrByte <= wrByte + 8'h01;
      #1;
      if (rdByteValid === 1'b1)
        lastRd = rdByte;
      nRd += (rdByteValid === 1'b1);
      nWr += (wrByteReq === 1'b1);
      if (opDone === 1'b1)
        break;
    end
    if (n == 20000)
    begin
      mismatches++;
      printVerdict();
    end
  endtask
  task automatic testRead();
    runOp(3'h0, 11'h005, 5'h02, 10'h12C, 10'h004);
    checkVec("readCount", 10'h004, 10'(nRd));
    checkVec("readByte", 10'h0FF, {2'b00, lastRd});
    checkVec("readStart", 10'h12C, startCol);
    checkVec("readArea", 10'h000, {8'h00, area});
    checkBit("readFail", 1'b0, opFail);
    $display("test read done");
  endtask
  task automatic testProg();
    logic [9:0] cols [3] = '{10'h00A, 10'h12C, 10'h208};
    logic [1:0] areas [3] = '{2'h0, 2'h0, 2'h2};
    for (int i = 0; i < 3; i++)
    begin
      runOp(3'h1, 11'h003, 5'h00, cols[i], 10'h003);
      checkVec("progStart", cols[i], startCol);
      checkVec("progBytes", 10'h003, 10'(nWr));
      checkVec("progArea", {8'h00, areas[i]}, {8'h00, area});
      checkBit("progFail", 1'b0, opFail);
    end
    $display("test program done");
  endtask
  task automatic testScan();
    runOp(3'h0, 11'h007, 5'h01, 10'h205, 10'h001);
    checkVec("markerByte", 10'h000, {2'b00, lastRd});
    runOp(3'h4, 11'h007, 5'h00, 10'h000, 10'h000);
    checkBit("badMarked", 1'b1, blockBad);
    runOp(3'h2, 11'h007, 5'h00, 10'h000, 10'h000);
    checkBit("eraseBad", 1'b1, opFail);
    runOp(3'h1, 11'h007, 5'h00, 10'h000, 10'h002);
    checkBit("progBad", 1'b1, opFail);
    runOp(3'h4, 11'h000, 5'h00, 10'h000, 10'h000);
    checkBit("blockZero", 1'b0, blockBad);
    $display("test scan done");
  endtask
  task automatic testFail();
    failProg = 1'b1;
    runOp(3'h1, 11'h009, 5'h03, 10'h000, 10'h002);
    checkBit("progFailSeen", 1'b1, opFail);
    // a fresh block, so the erase really runs and its status is read
    runOp(3'h2, 11'h00A, 5'h00, 10'h000, 10'h000);
    checkBit("eraseFailSeen", 1'b1, opFail);
    failProg = 1'b0;
    $display("test fail done");
  endtask
  task automatic testSlow();
    slow = 1'b1;
    runOp(3'h3, 11'h000, 5'h00, 10'h000, 10'h000);
    checkBit("resetFail", 1'b0, opFail);
    runOp(3'h0, 11'h001, 5'h00, 10'h000, 10'h002);
    checkBit("slowReadFail", 1'b0, opFail);
    checkVec("slowCount", 10'h002, 10'(nRd));
    slow = 1'b0;
    $display("test slow done");
  endtask
  task automatic testMidReset();
    @(posedge clock);
    opStart <= 1'b1;
    opCode <= 3'h0;
    opBlock <= 11'h004;
    @(posedge clock);
    opStart <= 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    opBlock <= 11'h007;
    repeat (2) @(posedge clock);
    #1;
    checkBit("tableCleared", 1'b0, blockBad);
    checkBit("idleAfterReset", 1'b0, hostBusy);
    runOp(3'h4, 11'h007, 5'h00, 10'h000, 10'h000);
    checkBit("rescanBad", 1'b1, blockBad);
    $display("test mid reset done");
  endtask
  // main sequence
  initial
  begin
    {rstn, opStart, slow, failProg, opCode, opBlock, opPage} = '0;
    {opColumn, opLength, wrByte, lastRd} = '0;
    {mismatches, samplesChecked} = '0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    testRead();
    testProg();
    testScan();
    testFail();
    testSlow();
    testMidReset();
    printVerdict();
  end
endmodule // tb_nand_column_pointer_and_bad_block
